/* File: hw/adc_seq.sv */
`default_nettype none
`include "adc_seq_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Result FIFO
module result_fifo #(
	parameter int WIDTH = `RES_W,
	parameter int DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	input wire logic clk_en,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = count_r != (AW+1)'(DEPTH);
	assign out_valid = count_r != '0;
	assign out_data = mem[rd_ptr_r];

	always_ff @(posedge clock) begin
		if (clk_en && push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else if (clk_en) begin
			if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop) count_r <= count_r + 1'b1;
			else if (pop && !push) count_r <= count_r - 1'b1;
		end
	end
endmodule : result_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - A conversion completes thirteen conversion-clock periods after its start edge.
// - Busy falls just after the fourteenth rising conversion-clock edge; the code keeps it high while the result FIFO is full.
// - Busy rises promptly after start strobe falls, except in nap mode.
// - Conversion starts on first clock edge at least 10 ns after strobe.
// - Both converters hold at one instant, each giving a 12-bit result.
// - Each converter picks one of two differential pairs.
// - Pseudo mode uses common input as negative, one of three as positive.
// - A host-writable 10-bit reference DAC code sets the reference output.
// - Host loads configuration words through the write strobe.
// - Twelve converting cycles, one precharge, two sampling: fifteen per sample.
// - Chip select high ignores read and write strobes and releases the data bus.
// - Write captures on strobe rise; read drives data after strobe falls.
module adc_seq
	import adc_seq_pkg::*;
(
	// Clock, reset and enable
	input wire logic clock,
	input wire logic nrst,
	input wire logic clk_en,
	// Converter pins
	input wire logic conversion_clock,
	input wire logic conversion_start_n,
	output logic busy,
	// Parallel port
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [`RES_W-1:0] data_in,
	output logic [`RES_W-1:0] data_out,
	output logic data_oe,
	// Analog front end
	input wire logic [`RES_W-1:0] sample_a,
	input wire logic [`RES_W-1:0] sample_b,
	output logic hold,
	output logic precharge,
	output mux_sel_t mux_sel,
	output logic [`DAC_W-1:0] reference_dac_code
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [`PIN_N-1:0] pin_s1_r;
	logic [`PIN_N-1:0] pin_s2_r;
	logic [`PIN_N-1:0] pin_prev_r;
	// Data bus synchroniser, aligned with the strobe lanes
	logic [`RES_W-1:0] din_s1_r;
	logic [`RES_W-1:0] din_s2_r;
	wire [`PIN_N-1:0] pin_raw = {wr_n, rd_n, cs_n, conversion_clock,
		conversion_start_n};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_s1_r <= `PIN_IDLE;
			pin_s2_r <= `PIN_IDLE;
			pin_prev_r <= `PIN_IDLE;
			din_s1_r <= '0;
			din_s2_r <= '0;
		end else if (clk_en) begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
			din_s1_r <= data_in;
			din_s2_r <= din_s1_r;
		end
	end

	wire [`PIN_N-1:0] pin_fall = pin_prev_r & ~pin_s2_r;
	wire [`PIN_N-1:0] pin_rise = ~pin_prev_r & pin_s2_r;
	wire selected = !pin_s2_r[`PIN_CS];
	wire start_fall = pin_fall[`PIN_CONV];
	wire cclk_rise = pin_rise[`PIN_CLK];
	wire rd_fall = pin_fall[`PIN_RD] && selected;
	wire wr_rise = pin_rise[`PIN_WR] && selected;

	////////////////////////////////////////////////////////////////////////////
	// Configuration and reference DAC
	cfg_t cfg_r;
	logic [`DAC_W-1:0] dac_r;
	wire dac_write = wr_rise && din_s2_r[`WSEL_BIT];
	wire cfg_write = wr_rise && !din_s2_r[`WSEL_BIT];

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfg_r <= `CFG_RESET;
			dac_r <= `DAC_RESET;
		end else if (clk_en) begin
			if (dac_write) dac_r <= din_s2_r[`DAC_W-1:0];
			if (cfg_write) begin
				cfg_r.c0 <= din_s2_r[`CFG_C0_BIT];
				cfg_r.c1 <= din_s2_r[`CFG_C1_BIT];
				cfg_r.pseudo <= din_s2_r[`CFG_PSEUDO_BIT];
				cfg_r.nap <= din_s2_r[`CFG_NAP_BIT];
			end
		end
	end

	assign reference_dac_code = dac_r;

	// Channel selection
	wire [1:0] csel = {cfg_r.c1, cfg_r.c0};
	wire [1:0] pos_diff = cfg_r.c1 ? `SEL_P1 : `SEL_P0;
	wire [1:0] neg_diff = cfg_r.c1 ? `SEL_N1 : `SEL_N0;
	wire [1:0] pos_pseudo = (csel == 2'h1) ? `SEL_N1 :
		(csel == 2'h2) ? `SEL_P1 : `SEL_P0;
	assign mux_sel.pos = cfg_r.pseudo ? pos_pseudo : pos_diff;
	assign mux_sel.neg = cfg_r.pseudo ? `SEL_N0 : neg_diff;

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [`SETUP_CNT_W-1:0] setup_r;
	logic [`EDGE_CNT_W-1:0] edge_r;
	logic busy_r;
	logic hold_r;
	result_pair_t res_r;
	logic fifo_in_ready;

	wire setup_met = setup_r >= `SETUP_CNT_W'(`START_SETUP_CYC);
	wire start_edge = (state_r == ST_WAIT_EDGE) && cclk_rise && setup_met;
	wire push_a = (state_r == ST_CONVERT) && (edge_r == `PUSH_A_EDGE - 1);
	wire push_b = (state_r == ST_CONVERT) && (edge_r == `PUSH_B_EDGE - 1);
	wire push_edge = (push_a || push_b) && cclk_rise;
	wire edge_step = (state_r == ST_CONVERT) && cclk_rise &&
		(!(push_a || push_b) || fifo_in_ready);
	wire last_edge = edge_step && (edge_r == `BUSY_DROP_EDGE - 1);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_fall) state_nxt = ST_WAIT_EDGE;
			end
			ST_WAIT_EDGE: begin
				if (start_edge) state_nxt = ST_CONVERT;
			end
			ST_CONVERT: begin
				if (last_edge) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			setup_r <= '0;
			edge_r <= '0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			if (state_r != ST_WAIT_EDGE) setup_r <= '0;
			else if (!setup_met) setup_r <= setup_r + 1'b1;
			if (start_edge) edge_r <= `FIRST_EDGE;
			else if (edge_step) edge_r <= edge_r + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			hold_r <= 1'b0;
			res_r <= '0;
		end else if (clk_en) begin
			if (start_fall && !cfg_r.nap) busy_r <= 1'b1;
			else if (start_edge) busy_r <= 1'b1;
			else if (last_edge) busy_r <= 1'b0;
			if (start_fall) begin
				hold_r <= 1'b1;
				res_r <= {sample_a, sample_b};
			end else if (edge_step && edge_r == `CONV_EDGES - 1) begin
				hold_r <= 1'b0;
			end
		end
	end

	assign busy = busy_r;
	assign hold = hold_r;
	assign precharge = (state_r == ST_CONVERT) &&
		(edge_r == `CONV_EDGES);

	////////////////////////////////////////////////////////////////////////////
	// Result buffer and read port
	logic fifo_out_valid;
	logic [`RES_W-1:0] fifo_out_data;
	logic [`RES_W-1:0] dout_r;
	logic oe_r;

	result_fifo #(
		.WIDTH(`RES_W),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.nrst(nrst),
		.clk_en(clk_en),
		.in_valid(push_edge),
		.in_ready(fifo_in_ready),
		.in_data(push_a ? res_r.a : res_r.b),
		.out_valid(fifo_out_valid),
		.out_ready(rd_fall),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dout_r <= '0;
			oe_r <= 1'b0;
		end else if (clk_en) begin
			oe_r <= selected && !pin_s2_r[`PIN_RD];
			if (rd_fall && fifo_out_valid) dout_r <= fifo_out_data;
		end
	end

	assign data_out = dout_r;
	assign data_oe = oe_r;
endmodule : adc_seq

`default_nettype wire

/* File: hw/adc_seq_consts.svh */
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// Widths and FIFO depth
`define RES_W 12
`define DAC_W 10
`define FIFO_DEPTH 16
`define EDGE_CNT_W 5

// Conversion timing, in conversion-clock rising edges
`define CONV_EDGES 13
`define BUSY_DROP_EDGE 14
`define PUSH_A_EDGE 13
`define PUSH_B_EDGE 14

// Start-strobe setup before a conversion-clock edge
`define START_SETUP_NS 10
`define SYS_CLK_MHZ 200
`define START_SETUP_CYC ((`START_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define SETUP_CNT_W 4

// Configuration word layout
`define WSEL_BIT 11
`define CFG_C0_BIT 0
`define CFG_C1_BIT 1
`define CFG_PSEUDO_BIT 2
`define CFG_NAP_BIT 3

// Reset values
`define DAC_RESET 10'h3FF
`define CFG_RESET 4'h0

// Pin synchroniser lanes
`define PIN_N 5
`define PIN_CONV 0
`define PIN_CLK 1
`define PIN_CS 2
`define PIN_RD 3
`define PIN_WR 4
`define PIN_IDLE 5'h1D

// Edge count loaded by the starting edge
`define FIRST_EDGE 5'h01

// Input selects
`define SEL_P0 2'h0
`define SEL_N1 2'h1
`define SEL_P1 2'h2
`define SEL_N0 2'h0

`endif

/* File: hw/adc_seq_pkg.sv */
`default_nettype none
`include "adc_seq_consts.svh"

package adc_seq_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_EDGE,
		ST_CONVERT
	} seq_state_t;

	typedef struct packed {
		logic nap;
		logic pseudo;
		logic c1;
		logic c0;
	} cfg_t;

	// Positive: 0 pair0+, 1 pair1-, 2 pair1+; negative: 0 common, 1 pair1-
	typedef struct packed {
		logic [1:0] pos;
		logic [1:0] neg;
	} mux_sel_t;

	typedef struct packed {
		logic [`RES_W-1:0] a;
		logic [`RES_W-1:0] b;
	} result_pair_t;

endpackage : adc_seq_pkg

`default_nettype wire

/* File: bench/adc_seq_chk.sv */
`default_nettype none
module adc_seq_chk
	import adc_seq_pkg::*;
(
	// Watched ports
	input wire logic clock,
	input wire logic nrst,
	input wire logic conversion_clock,
	input wire logic conversion_start_n,
	input wire logic busy,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [11:0] data_in,
	input wire logic [11:0] data_out,
	input wire logic data_oe,
	input wire logic hold,
	input wire logic precharge,
	input wire logic [9:0] reference_dac_code
);
	logic nap_r;
	logic [4:0] edge_cnt_r;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			nap_r <= 1'b0;
			edge_cnt_r <= 5'h00;
		end else begin
			if ($rose(wr_n) && !cs_n && !data_in[11])
				nap_r <= data_in[3];
			if ($fell(conversion_start_n))
				edge_cnt_r <= 5'h00;
			else if ($rose(conversion_clock) && edge_cnt_r != 5'h1F)
				edge_cnt_r <= edge_cnt_r + 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_rise; $fell(conversion_start_n) && !busy && !nap_r
		|-> ##[1:6] busy; endproperty
	property p_len; $fell(busy) |-> edge_cnt_r >= 5'h0E; endproperty
	property p_held; $rose(busy) |-> hold; endproperty
	property p_pre; $rose(precharge) |-> busy && !hold; endproperty
	property p_off; (cs_n || rd_n) [*5] |-> !data_oe; endproperty
	property p_on; (!cs_n && !rd_n) [*5] |-> data_oe; endproperty
	property p_dout; data_oe && $past(data_oe) |-> $stable(data_out);
	endproperty
	property p_dac; $rose(wr_n) && !cs_n && data_in[11]
		|-> ##3 reference_dac_code == $past(data_in[9:0], 3); endproperty
	a_rise: assert property (p_rise) else $error("busy late");
	a_len: assert property (p_len) else $error("busy short");
	a_held: assert property (p_held) else $error("no hold");
	a_pre: assert property (p_pre) else $error("precharge");
	a_off: assert property (p_off) else $error("bus driven");
	a_on: assert property (p_on) else $error("bus idle");
	a_dout: assert property (p_dout) else $error("data moved");
	a_dac: assert property (p_dac) else $error("dac code");
	c_conv: cover property ($fell(busy));
	c_read: cover property ($rose(data_oe));
	c_dac: cover property ($changed(reference_dac_code));
endmodule : adc_seq_chk
bind adc_seq adc_seq_chk chk (.clock, .nrst, .conversion_clock,
	.conversion_start_n, .busy, .cs_n, .rd_n, .wr_n, .data_in, .data_out,
	.data_oe, .hold, .precharge, .reference_dac_code);
`default_nettype wire

/* File: bench/host_model.sv */
`default_nettype none
module host_model (
	// Clock
	input wire logic clock,
	// Host pins
	output logic conversion_start_n,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [11:0] data_in,
	// Device pins
	input wire logic busy,
	input wire logic [11:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Busy level seen four cycles after the start strobe fell
	logic busy_early;
	initial begin
		busy_early = 1'b0;
		conversion_start_n = 1'b1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		data_in = 12'h5A5;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clock);
	endtask : w
	task automatic write(input logic [11:0] v, input logic sel);
		data_in = v;
		cs_n = !sel;
		w(1);
		wr_n = 1'b0;
		w(4);
		wr_n = 1'b1;
		w(5);
		cs_n = 1'b1;
		data_in = ~v;
		w(2);
	endtask : write
	task automatic conv();
		int k;
		conversion_start_n = 1'b0;
		w(4);
		busy_early = busy;
		w(1);
		conversion_start_n = 1'b1;
		// Nap mode raises busy only when the conversion starts
		for (k = 0; k < 40 && !busy; k++) w(1);
		for (k = 0; k < 300 && busy; k++) w(1);
	endtask : conv
	task automatic read2(output logic [11:0] a, output logic [11:0] b);
		cs_n = 1'b0;
		w(1);
		rd_n = 1'b0;
		w(6);
		a = data_out;
		rd_n = 1'b1;
		w(4);
		rd_n = 1'b0;
		w(6);
		b = data_out;
		rd_n = 1'b1;
		w(2);
		cs_n = 1'b1;
		w(2);
	endtask : read2
endmodule : host_model
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic conversion_clock = 1'b0;
	logic [11:0] sample_a = 12'h000;
	logic [11:0] sample_b = 12'h000;
	logic [11:0] ra, rb;
	wire conversion_start_n, cs_n, rd_n, wr_n, busy, data_oe;
	wire [11:0] data_in, data_out;
	wire [3:0] mux_sel;
	wire [9:0] reference_dac_code;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2.5 clock = ~clock;
	always #20 conversion_clock = ~conversion_clock;
	adc_seq DUT (.clock, .nrst, .clk_en, .conversion_clock,
		.conversion_start_n, .busy, .cs_n, .rd_n, .wr_n, .data_in,
		.data_out, .data_oe, .sample_a, .sample_b, .hold(), .precharge(),
		.mux_sel, .reference_dac_code);
	host_model host (.clock, .conversion_start_n, .cs_n, .rd_n, .wr_n,
		.data_in, .busy, .data_out);
	task automatic test_done();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	always @(posedge clock) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK(busy, 1'b0)
		`CHK(data_oe, 1'b0)
		`CHK(reference_dac_code, 10'h3FF)
		$display("t_reset done");
	endtask : t_reset
	task automatic t_cfg();
		logic [3:0] e [5] = '{4'h0, 4'h4, 4'h8, 4'h0, 4'h9};
		logic [11:0] v [5] = '{12'h004, 12'h005, 12'h006, 12'h000, 12'h003};
		for (int i = 0; i < 5; i++) begin
			host.write(v[i], 1'b1);
			`CHK(mux_sel, e[i])
		end
		$display("t_cfg done");
	endtask : t_cfg
	task automatic t_dac();
		host.write(12'h8CD, 1'b1);
		`CHK(reference_dac_code, 10'h0CD)
		host.write(12'h9FD, 1'b0);
		`CHK(reference_dac_code, 10'h0CD)
		host.write(12'hBFD, 1'b1);
		`CHK(reference_dac_code, 10'h3FD)
		$display("t_dac done");
	endtask : t_dac
	task automatic t_freeze();
		clk_en = 1'b0;
		host.write(12'h001, 1'b1);
		clk_en = 1'b1;
		host.w(2);
		`CHK(mux_sel, 4'h9)
		$display("t_freeze done");
	endtask : t_freeze
	task automatic t_nap();
		host.write(12'h00B, 1'b1);
		sample_a = 12'hC3A;
		sample_b = 12'h1E7;
		host.conv();
		`CHK(host.busy_early, 1'b0)
		host.read2(ra, rb);
		`CHK(ra, 12'hC3A)
		`CHK(rb, 12'h1E7)
		host.write(12'h003, 1'b1);
		`CHK(mux_sel, 4'h9)
		$display("t_nap done");
	endtask : t_nap
	task automatic t_conv();
		longint t0;
		longint n;
		sample_a = 12'h8A5;
		sample_b = 12'h35C;
		t0 = $time;
		host.conv();
		n = ($time - t0) / 5;
		`CHK(n >= 108 && n <= 122, 1'b1)
		`CHK(host.busy_early, 1'b1)
		host.read2(ra, rb);
		`CHK(ra, 12'h8A5)
		`CHK(rb, 12'h35C)
		$display("t_conv done");
	endtask : t_conv
	task automatic t_fifo();
		for (int i = 0; i < 9; i++) begin
			sample_a = 12'h100 + 12'(i);
			sample_b = 12'h200 + 12'(i);
			host.conv();
		end
		`CHK(busy, 1'b1)
		for (int i = 0; i < 9; i++) begin
			host.read2(ra, rb);
			`CHK(ra, 12'h100 + 12'(i))
			`CHK(rb, 12'h200 + 12'(i))
			for (int k = 0; k < 300 && busy; k++) host.w(1);
		end
		host.read2(ra, rb);
		`CHK(rb, 12'h208)
		$display("t_fifo done");
	endtask : t_fifo
	initial begin
		repeat (6) @(negedge clock);
		nrst = 1'b1;
		repeat (4) @(negedge clock);
		t_reset();
		t_cfg();
		t_dac();
		t_freeze();
		t_conv();
		t_nap();
		t_fifo();
		test_done();
	end
endmodule : testbench
`default_nettype wire
